// ### shared/mbs_defs.svh
// Purpose: Named constants of the serial register access block
// Assumes: 10 MHz reference clock
// Notes: Bit times are rounded down to whole clock cycles
`ifndef MBS_DEFS_SVH
`define MBS_DEFS_SVH
`define MBS_CLK_HZ 10000000
`define MBS_NREG 16
`define MBS_NREG_NUM 17'h00010
`define MBS_UNIT_DEF 8'h01
`define MBS_BAUD_DEF 3'h1
`define MBS_WORD_BITS 5'h16
`define MBS_BIT_CYC(b) (`MBS_CLK_HZ / (b))
`define MBS_BAUD_SEL_4800 3'h0
`define MBS_BAUD_SEL_9600 3'h1
`define MBS_BAUD_SEL_19200 3'h2
`define MBS_BAUD_SEL_38400 3'h3
`define MBS_BAUD_SEL_57600 3'h4
`define MBS_BAUD_SEL_115200 3'h5
`define MBS_FMT_U16 3'h0
`define MBS_FMT_S16 3'h1
`define MBS_FMT_WIDE_HEAD 3'h2
`define MBS_FMT_WIDE_TAIL 3'h3
`define MBS_FMT_STR_HEAD 3'h4
`define MBS_FMT_STR_BODY 3'h5
`define MBS_FN_RD_COIL 8'h01
`define MBS_FN_RD_DISC 8'h02
`define MBS_FN_RD_HOLD 8'h03
`define MBS_FN_RD_INP 8'h04
`define MBS_FN_WR_COIL 8'h05
`define MBS_FN_WR_HOLD 8'h06
`define MBS_FN_WR_COILS 8'h0F
`define MBS_FN_WR_HOLDS 8'h10
`define MBS_EXC_FUNC 8'h01
`define MBS_EXC_ADDR 8'h02
`define MBS_EXC_FLAG 8'h80
`define MBS_PAR_NONE 2'h0
`define MBS_PAR_EVEN 2'h1
`define MBS_PAR_ODD 2'h2
`endif

// ### shared/mbs_pkg.sv
// Purpose: Types of the serial register access block
// Assumes: Nothing
// Notes: States are one-hot
package mbs_pkg;
  typedef enum logic [5:0] {
    MBS_IDLE = 6'h01,
    MBS_CHECK = 6'h02,
    MBS_WRITE = 6'h04,
    MBS_ACK = 6'h08,
    MBS_READ = 6'h10,
    MBS_EXC = 6'h20
  } mbs_state_type;
  typedef logic [2:0] mbs_fmt_type;
endpackage

// ### src/mbs_bit_timer.sv
// Purpose: Bit-time tick generator for the selected baud rate
// Assumes: Selection is stable while a response is paced
// Notes: Unknown selections fall back to 9600 baud
`timescale 1ns/100ps
`include "mbs_defs.svh"
module mbs_bit_timer import mbs_pkg::*; (
  input wire logic ref_clk, // Clock
  input wire logic arst_n, // Async reset
  input wire logic [2:0] baud_sel, // Baud code
  output logic bit_tick // One pulse per bit time
);
  logic [11:0] count;
  logic [11:0] limit;

  always_comb begin
    unique case (baud_sel)
      `MBS_BAUD_SEL_4800: limit = 12'(`MBS_BIT_CYC(4800) - 1);
      `MBS_BAUD_SEL_19200: limit = 12'(`MBS_BIT_CYC(19200) - 1);
      `MBS_BAUD_SEL_38400: limit = 12'(`MBS_BIT_CYC(38400) - 1);
      `MBS_BAUD_SEL_57600: limit = 12'(`MBS_BIT_CYC(57600) - 1);
      `MBS_BAUD_SEL_115200: limit = 12'(`MBS_BIT_CYC(115200) - 1);
      default: limit = 12'(`MBS_BIT_CYC(9600) - 1);
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 12'h000;
      bit_tick <= 1'b0;
    end else if (count >= limit) begin
      count <= 12'h000;
      bit_tick <= 1'b1;
    end else begin
      count <= count + 12'h001;
      bit_tick <= 1'b0;
    end
  end

  tick_gap_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    bit_tick |=> !bit_tick[*8]) else $error("bit tick too frequent");
endmodule

// ### src/mbs_slave_access.sv
// Purpose: Serial slave register access: request checks, local register file, paced answers
// Assumes: Framing and CRC handled upstream; requests and write words arrive as decoded fields
// Notes: Master-side settings have no effect here
`timescale 1ns/100ps
`include "mbs_defs.svh"
module mbs_slave_access import mbs_pkg::*; (
  input wire logic ref_clk, // Clock
  input wire logic arst_n, // Async reset
  input wire logic cfg_load, // Load settings below
  input wire logic [2:0] cfg_baud, // Baud code
  input wire logic [1:0] cfg_parity, // Parity mode
  input wire logic [7:0] cfg_unit, // Own unit number
  input wire logic cfg_slave, // Slave mode on
  input wire logic loc_we, // Local register write
  input wire logic [4:0] loc_num, // Local register number 1..16
  input wire logic [15:0] loc_data, // Local write data
  input wire logic [2:0] loc_fmt, // Local register format
  input wire logic req_valid, // Request present
  input wire logic [7:0] req_unit, // Request unit number
  input wire logic [7:0] req_func, // Function code
  input wire logic [15:0] req_addr, // First register number
  input wire logic [15:0] req_count, // Register count
  input wire logic wd_valid, // Write word present
  input wire logic [15:0] wd_data, // Write word
  output logic wd_ready, // Write word wanted
  output logic busy, // Request in progress
  output logic resp_valid, // Answer word pulse
  output logic [15:0] resp_word, // Answer word
  output logic resp_exc, // Answer is an exception
  output logic resp_last, // Last answer word
  output logic [1:0] resp_par // Parity of high, low byte
);
  mbs_state_type state;
  logic [15:0] mem [0:`MBS_NREG-1];
  mbs_fmt_type fmt [0:`MBS_NREG-1];
  logic [7:0] my_unit, r_func, exc_code;
  logic [2:0] baud;
  logic [1:0] par_mode;
  logic slave_en, is_bit, bit_tick;
  logic [15:0] r_addr, r_cnt;
  logic [3:0] ptr;
  logic [16:0] left;
  logic [4:0] gap;
  logic func_ok, wr_fn, bit_fn, bad_range, misalign, wide_hit, emit, m_we;
  logic [16:0] end_num, num;
  logic [15:0] rd_word, out_word;

  mbs_bit_timer timer (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .baud_sel(baud),
    .bit_tick(bit_tick)
  );

  // Settings; master-only parameters have no port and no effect
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      my_unit <= `MBS_UNIT_DEF;
      baud <= `MBS_BAUD_DEF;
      par_mode <= `MBS_PAR_NONE;
      slave_en <= 1'b1;
    end else if (cfg_load) begin
      my_unit <= cfg_unit;
      baud <= cfg_baud;
      par_mode <= cfg_parity;
      slave_en <= cfg_slave;
    end
  end

  always_comb begin
    bit_fn = (r_func == `MBS_FN_RD_COIL) || (r_func == `MBS_FN_RD_DISC) ||
             (r_func == `MBS_FN_WR_COIL) || (r_func == `MBS_FN_WR_COILS);
    // Input register type has no write function
    wr_fn = (r_func == `MBS_FN_WR_COIL) || (r_func == `MBS_FN_WR_HOLD) ||
            (r_func == `MBS_FN_WR_COILS) || (r_func == `MBS_FN_WR_HOLDS);
    // Single and multiple write forms are both served whatever is set for master use
    func_ok = bit_fn || wr_fn || (r_func == `MBS_FN_RD_HOLD) || (r_func == `MBS_FN_RD_INP);
    end_num = {1'b0, r_addr} + {1'b0, r_cnt} - 17'h00001;
    bad_range = (r_addr == 16'h0000) || (r_cnt == 16'h0000) || (end_num > `MBS_NREG_NUM);
    wide_hit = 1'b0;
    misalign = 1'b0;
    num = 17'h00000;
    for (int i = 0; i < `MBS_NREG; i++) begin
      num = 17'(i + 1);
      if (num >= {1'b0, r_addr} && num <= end_num &&
          fmt[i] != `MBS_FMT_U16 && fmt[i] != `MBS_FMT_S16) begin
        wide_hit = 1'b1;
      end
      if ((num == {1'b0, r_addr} || num == end_num + 17'h00001) &&
          (fmt[i] == `MBS_FMT_WIDE_TAIL || fmt[i] == `MBS_FMT_STR_BODY)) begin
        misalign = 1'b1;
      end
    end
  end

  assign emit = (state == MBS_ACK || state == MBS_READ || state == MBS_EXC) && gap == `MBS_WORD_BITS;
  assign m_we = state == MBS_WRITE && wd_valid && wd_ready;

  // Busy tracks the state register: set on a taken request, cleared with the last answer word
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
    end else if (state == MBS_IDLE) begin
      busy <= req_valid && slave_en && req_unit == my_unit;
    end else if (emit && (state != MBS_READ || left == 17'h00001)) begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= MBS_IDLE;
      r_func <= 8'h00;
      r_addr <= 16'h0000;
      r_cnt <= 16'h0000;
      exc_code <= 8'h00;
      ptr <= 4'h0;
      left <= 17'h00000;
      wd_ready <= 1'b0;
      is_bit <= 1'b0;
    end else begin
      unique case (state)
        MBS_IDLE: begin
          if (req_valid && slave_en && req_unit == my_unit) begin
            state <= MBS_CHECK;
            r_func <= req_func;
            r_addr <= req_addr;
            r_cnt <= (req_func == `MBS_FN_WR_COIL || req_func == `MBS_FN_WR_HOLD) ? 16'h0001 : req_count;
          end
        end
        MBS_CHECK: begin
          ptr <= 4'(r_addr - 16'h0001);
          left <= {1'b0, r_cnt};
          is_bit <= bit_fn;
          if (!func_ok) begin
            exc_code <= `MBS_EXC_FUNC;
            state <= MBS_EXC;
          end else if (bad_range || misalign || (bit_fn && wide_hit)) begin
            exc_code <= `MBS_EXC_ADDR;
            state <= MBS_EXC;
          end else if (wr_fn) begin
            state <= MBS_WRITE;
            wd_ready <= 1'b1;
          end else begin
            state <= MBS_READ;
          end
        end
        MBS_WRITE: begin
          if (m_we) begin
            ptr <= ptr + 4'h1;
            left <= left - 17'h00001;
            if (left == 17'h00001) begin
              wd_ready <= 1'b0;
              state <= MBS_ACK;
            end
          end
        end
        MBS_READ: begin
          if (emit) begin
            ptr <= ptr + 4'h1;
            left <= left - 17'h00001;
            if (left == 17'h00001) begin
              state <= MBS_IDLE;
            end
          end
        end
        MBS_ACK, MBS_EXC: begin
          if (emit) begin
            state <= MBS_IDLE;
          end
        end
      endcase
    end
  end

  // Answer spacing counts bit times at the configured rate
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap <= 5'h00;
    end else if (!(state == MBS_ACK || state == MBS_READ || state == MBS_EXC) || emit) begin
      gap <= 5'h00;
    end else if (bit_tick) begin
      gap <= gap + 5'h01;
    end
  end

  // Master write wins over a local write in the same cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `MBS_NREG; i++) begin
        mem[i] <= 16'h0000;
        fmt[i] <= `MBS_FMT_U16;
      end
    end else if (m_we) begin
      mem[ptr] <= is_bit ? {15'h0000, |wd_data} : wd_data;
    end else if (loc_we && loc_num != 5'h00 && loc_num <= 5'(`MBS_NREG)) begin
      mem[4'(loc_num - 5'h01)] <= loc_data;
      fmt[4'(loc_num - 5'h01)] <= loc_fmt;
    end
  end

  always_comb begin
    rd_word = is_bit ? {15'h0000, |mem[ptr]} : mem[ptr];
    if (state == MBS_EXC) begin
      out_word = {r_func | `MBS_EXC_FLAG, exc_code};
    end else if (state == MBS_ACK) begin
      out_word = r_addr;
    end else begin
      out_word = rd_word;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      resp_valid <= 1'b0;
      resp_word <= 16'h0000;
      resp_exc <= 1'b0;
      resp_last <= 1'b0;
      resp_par <= 2'h0;
    end else begin
      resp_valid <= emit;
      if (emit) begin
        resp_word <= out_word;
        resp_exc <= state == MBS_EXC;
        resp_last <= state != MBS_READ || left == 17'h00001;
        if (par_mode == `MBS_PAR_NONE) begin
          resp_par <= 2'h0;
        end else begin
          resp_par <= {^out_word[15:8], ^out_word[7:0]} ^ {2{par_mode == `MBS_PAR_ODD}};
        end
      end
    end
  end

  other_unit_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state == MBS_IDLE && req_valid && req_unit != my_unit |=> state == MBS_IDLE)
    else $error("answered foreign unit");
  coil_wide_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state == MBS_CHECK && func_ok && bit_fn && wide_hit |=> state == MBS_EXC && exc_code == `MBS_EXC_ADDR)
    else $error("bit access to wide register");
  // The answer word itself comes many bit times later; exc_word_a checks it
  misalign_exc_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state == MBS_CHECK && func_ok && misalign |=> state == MBS_EXC && exc_code == `MBS_EXC_ADDR)
    else $error("partial wide access not refused");
  exc_word_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    emit && state == MBS_EXC |=> resp_valid && resp_exc && resp_last && resp_word[7:0] == exc_code)
    else $error("exception word wrong");
  input_ro_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    m_we |-> r_func != `MBS_FN_RD_INP && r_func != `MBS_FN_RD_HOLD)
    else $error("write through read type");
  bit_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    emit && state == MBS_READ && is_bit |=> resp_word == {15'h0000, $past(mem[ptr]) != 16'h0000})
    else $error("bit read value wrong");
  hold_write_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    m_we && !is_bit |=> mem[$past(ptr)] == $past(wd_data))
    else $error("holding write lost");
  reset_cfg_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $past(!arst_n) |-> my_unit == `MBS_UNIT_DEF && baud == `MBS_BAUD_SEL_9600)
    else $error("factory settings wrong");
  word_pace_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    resp_valid |=> !resp_valid[*8]) else $error("answers not paced");
  reg_select_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state == MBS_CHECK && func_ok && !bad_range |=> ptr == 4'($past(r_addr) - 16'h0001))
    else $error("register number translated");
endmodule

// ### tb/mbs_master_model.sv
// Purpose: Remote serial master issuing decoded requests and collecting answer words
// Assumes: Caller starts each request just after a rising edge while the slave is idle
// Notes: Released request and write fields are scrambled so stale values never match
`timescale 1ns/100ps
module mbs_master_model (
  input wire logic ref_clk, // Clock
  input wire logic busy, // Slave busy
  input wire logic wd_ready, // Write word wanted
  input wire logic resp_valid, // Answer pulse
  input wire logic [15:0] resp_word, // Answer word
  input wire logic resp_exc, // Exception flag
  input wire logic resp_last, // Last word flag
  input wire logic [1:0] resp_par, // Byte parities
  output logic req_valid, // Request present
  output logic [7:0] req_unit, // Unit number
  output logic [7:0] req_func, // Function code
  output logic [15:0] req_addr, // First number
  output logic [15:0] req_count, // Count
  output logic wd_valid, // Write word present
  output logic [15:0] wd_data // Write word
);
  logic [19:0] rq[$];
  logic [15:0] wq[$];
  initial begin
    req_valid = 1'b0;
    req_unit = 8'h00;
    req_func = 8'h00;
    req_addr = 16'h0000;
    req_count = 16'h0000;
    wd_valid = 1'b0;
    wd_data = 16'h0000;
  end
  always @(posedge ref_clk) begin
    if (resp_valid === 1'b1) begin
      rq.push_back({resp_par, resp_exc, resp_last, resp_word});
    end
  end
  task automatic send(input logic [7:0] u, f, input logic [15:0] a, c);
    while (busy !== 1'b0) @(posedge ref_clk);
    req_valid <= 1'b1;
    req_unit <= u;
    req_func <= f;
    req_addr <= a;
    req_count <= c;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    req_unit <= ~u;
    req_func <= ~f;
    req_addr <= ~a;
    req_count <= ~c;
    while (wq.size() > 0) begin
      wd_valid <= 1'b1;
      wd_data <= wq.pop_front();
      @(negedge ref_clk);
      while (wd_ready !== 1'b1) @(negedge ref_clk);
      @(posedge ref_clk);
    end
    wd_valid <= 1'b0;
    wd_data <= ~wd_data;
  endtask
endmodule

// ### tb/mbs_slave_access_tb.sv
// Purpose: Self-checking bench of the serial slave register access block
// Assumes: Answers paced at 9600 baud first, then at 115200 baud
// Notes: Each answer entry is {parity, exception, last, word}
`timescale 1ns/100ps
`include "mbs_defs.svh"
module mbs_slave_access_tb;
  logic ref_clk = 1'b0, arst_n = 1'b0, cfg_load = 1'b0, cfg_slave = 1'b1, loc_we = 1'b0;
  logic [2:0] cfg_baud = 3'h1, loc_fmt = 3'h0;
  logic [1:0] cfg_parity = 2'h0, resp_par;
  logic [7:0] cfg_unit = 8'h01, req_unit, req_func;
  logic [4:0] loc_num = 5'h00;
  logic [15:0] loc_data = 16'h0000, req_addr, req_count, wd_data, resp_word;
  logic req_valid, wd_valid, wd_ready, busy, resp_valid, resp_exc, resp_last;
  logic [1:0] pm = 2'h0;
  int fail_count = 0, tests_run = 0, first_at = 0;
  logic [15:0] vals [7] = '{16'h0107, 16'h0000, 16'h4120, 16'h0001, 16'h4142, 16'h4344, 16'h4546};
  logic [2:0] fmts [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5};
  always #50 ref_clk = ~ref_clk;
  mbs_slave_access DUT (.ref_clk(ref_clk), .arst_n(arst_n), .cfg_load(cfg_load), .cfg_baud(cfg_baud),
    .cfg_parity(cfg_parity), .cfg_unit(cfg_unit), .cfg_slave(cfg_slave), .loc_we(loc_we),
    .loc_num(loc_num), .loc_data(loc_data), .loc_fmt(loc_fmt), .req_valid(req_valid),
    .req_unit(req_unit), .req_func(req_func), .req_addr(req_addr), .req_count(req_count),
    .wd_valid(wd_valid), .wd_data(wd_data), .wd_ready(wd_ready), .busy(busy),
    .resp_valid(resp_valid), .resp_word(resp_word), .resp_exc(resp_exc), .resp_last(resp_last),
    .resp_par(resp_par));
  mbs_master_model mm (.ref_clk(ref_clk), .busy(busy), .wd_ready(wd_ready), .resp_valid(resp_valid),
    .resp_word(resp_word), .resp_exc(resp_exc), .resp_last(resp_last), .resp_par(resp_par),
    .req_valid(req_valid), .req_unit(req_unit), .req_func(req_func), .req_addr(req_addr),
    .req_count(req_count), .wd_valid(wd_valid), .wd_data(wd_data));
  task automatic chk(input string nm, input logic [19:0] e, g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Expected entry; per-byte parity bit makes the count of ones even or odd
  task automatic ck(input int i, input logic [15:0] wv, input logic x, l);
    logic [1:0] p;
    p = {^wv[15:8], ^wv[7:0]};
    if (pm == `MBS_PAR_ODD) p = ~p;
    if (pm == `MBS_PAR_NONE) p = 2'b00;
    chk("answer", {p, x, l, wv}, mm.rq[i]);
  endtask
  task automatic cfg(input logic [2:0] b, input logic [1:0] p, input logic [7:0] un, input logic sl);
    cfg_load <= 1'b1;
    cfg_baud <= b;
    cfg_parity <= p;
    cfg_unit <= un;
    cfg_slave <= sl;
    @(posedge ref_clk);
    cfg_load <= 1'b0;
    pm = p;
  endtask
  task automatic run(input logic [7:0] u, f, input logic [15:0] a, c, input int n);
    mm.rq.delete();
    mm.send(u, f, a, c);
    if (n == 0) repeat (2500) @(posedge ref_clk);
    first_at = 0;
    for (int k = 0; k < 25000 * n && mm.rq.size() < n; k++) begin
      @(posedge ref_clk);
      if (mm.rq.size() == 0) first_at = k + 1;
    end
    @(negedge ref_clk);
    while (busy !== 1'b0) @(negedge ref_clk);
    @(posedge ref_clk);
    chk("word count", 20'(n), 20'(mm.rq.size()));
  endtask
  task t_default;
    run(8'h01, 8'h03, 16'h0001, 16'h0001, 1);
    ck(0, 16'h0000, 1'b0, 1'b1);
    chk("pace 9600", 20'h00001,
        20'(first_at > 21 * `MBS_BIT_CYC(9600) && first_at < 23 * `MBS_BIT_CYC(9600)));
  endtask
  task t_config;
    cfg(`MBS_BAUD_SEL_115200, `MBS_PAR_EVEN, 8'h22, 1'b1);
    run(8'h01, 8'h03, 16'h0001, 16'h0001, 0);
    cfg(`MBS_BAUD_SEL_115200, `MBS_PAR_EVEN, 8'h22, 1'b0);
    run(8'h22, 8'h03, 16'h0001, 16'h0001, 0);
    cfg(`MBS_BAUD_SEL_115200, `MBS_PAR_EVEN, 8'h22, 1'b1);
    for (int i = 0; i < 7; i++) begin
      loc_we <= 1'b1;
      loc_num <= 5'(i + 1);
      loc_data <= vals[i];
      loc_fmt <= fmts[i];
      @(posedge ref_clk);
    end
    loc_we <= 1'b0;
  endtask
  task t_hold;
    run(8'h22, 8'h03, 16'h0001, 16'h0002, 2);
    ck(0, 16'h0107, 1'b0, 1'b0);
    ck(1, 16'h0000, 1'b0, 1'b1);
    chk("pace 115200", 20'h00001,
        20'(first_at > 21 * `MBS_BIT_CYC(115200) && first_at < 23 * `MBS_BIT_CYC(115200)));
  endtask
  task t_bits;
    run(8'h22, 8'h01, 16'h0001, 16'h0002, 2);
    ck(0, 16'h0001, 1'b0, 1'b0);
    ck(1, 16'h0000, 1'b0, 1'b1);
    run(8'h22, 8'h02, 16'h0003, 16'h0001, 1);
    ck(0, {8'h82, `MBS_EXC_ADDR}, 1'b1, 1'b1);
    run(8'h22, 8'h07, 16'h0001, 16'h0001, 1);
    ck(0, {8'h87, `MBS_EXC_FUNC}, 1'b1, 1'b1);
  endtask
  task t_write;
    mm.wq.push_back(16'h5A5A);
    run(8'h22, 8'h06, 16'h0002, 16'h0001, 1);
    ck(0, 16'h0002, 1'b0, 1'b1);
    run(8'h22, 8'h04, 16'h0002, 16'h0001, 1);
    ck(0, 16'h5A5A, 1'b0, 1'b1);
    mm.wq.push_back(16'h0000);
    run(8'h22, 8'h05, 16'h0001, 16'h0001, 1);
    ck(0, 16'h0001, 1'b0, 1'b1);
    run(8'h22, 8'h02, 16'h0001, 16'h0001, 1);
    ck(0, 16'h0000, 1'b0, 1'b1);
  endtask
  task t_wide;
    run(8'h22, 8'h03, 16'h0004, 16'h0001, 1);
    ck(0, {8'h83, `MBS_EXC_ADDR}, 1'b1, 1'b1);
    run(8'h22, 8'h03, 16'h0002, 16'h0002, 1);
    ck(0, {8'h83, `MBS_EXC_ADDR}, 1'b1, 1'b1);
    run(8'h22, 8'h03, 16'h0003, 16'h0002, 2);
    ck(0, 16'h4120, 1'b0, 1'b0);
    ck(1, 16'h0001, 1'b0, 1'b1);
  endtask
  task t_str;
    run(8'h22, 8'h03, 16'h0006, 16'h0002, 1);
    ck(0, {8'h83, `MBS_EXC_ADDR}, 1'b1, 1'b1);
    mm.wq = '{16'h6162, 16'h6364, 16'h6566};
    run(8'h22, 8'h10, 16'h0005, 16'h0003, 1);
    ck(0, 16'h0005, 1'b0, 1'b1);
    run(8'h22, 8'h03, 16'h0005, 16'h0003, 3);
    for (int i = 0; i < 3; i++) ck(i, 16'h6162 + 16'(i) * 16'h0202, 1'b0, 1'(i == 2));
    cfg(`MBS_BAUD_SEL_115200, `MBS_PAR_ODD, 8'h22, 1'b1);
    run(8'h22, 8'h04, 16'h0003, 16'h0002, 2);
    ck(0, 16'h4120, 1'b0, 1'b0);
    ck(1, 16'h0001, 1'b0, 1'b1);
  endtask
  task final_report;
    if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #10000000;
    fail_count++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    t_default;
    t_config;
    t_hold;
    t_bits;
    t_write;
    t_wide;
    t_str;
    final_report;
  end
endmodule
